/* common/iccd_pkg.sv */
// constants and types for the start/stop collision detector
// How it works
// - START sees either line low: collision
// - START collision aborts, flags, goes idle
// - SDA high: load counter, count down
// - SCL low while SDA high during first count: collision
// - SDA low during first count: drive early
// - count ends: SDA low, second count
// - second count ends: SCL low, done
// - repeated start: count, release SCL
// - SDA low after SCL rises: collision
// - SDA falling in next count: no collision
// - SCL falls before SDA driven: collision
// - both high: SDA low, count, SCL low
// - STOP: SDA low, release SCL, count
// - SDA low after release and count: collision
// - SCL low before SDA released: collision
// - collision releases lines, clears condition enables
// - released SDA read low at the start check, after SCL rises or at the end of stop: collision, idle
package iccd_pkg;

    localparam int ICCD_BRG_W = 7;
    localparam logic [ICCD_BRG_W-1:0] ICCD_CNT_RST = 7'h00;
    localparam logic ICCD_FLAG_RST = 1'b0;
    localparam logic ICCD_LINE_RST = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_S_CHK,
        ST_S_CNT1,
        ST_S_CNT2,
        ST_RS_WSDA,
        ST_RS_CNT1,
        ST_RS_WSCL,
        ST_RS_CNT2,
        ST_RS_CNT3,
        ST_P_WSDA,
        ST_P_WSCL,
        ST_P_CNT1,
        ST_P_CNT2
    } iccd_state_t;

    typedef struct packed {
        iccd_state_t st;
        logic [ICCD_BRG_W-1:0] cnt;
        logic sda_drv;
        logic scl_drv;
        logic flag;
        logic start_en;
        logic rstart_en;
        logic stop_en;
        logic done;
        logic sda_m;
        logic sda_s;
        logic scl_m;
        logic scl_s;
    } iccd_regs_t;

endpackage

/* rtl/iccd_core.sv */
// start, repeated start and stop generation with bus collision detection
`timescale 1ns/100ps
`default_nettype none
module iccd_core
    import iccd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // condition requests, one-cycle pulses, taken only while idle
    input wire logic start_req,
    input wire logic rstart_req,
    input wire logic stop_req,
    input wire logic [ICCD_BRG_W-1:0] brg_reload_value,
    input wire logic flag_clear,
    // status
    output logic start_en,
    output logic rstart_en,
    output logic stop_en,
    output logic cond_done,
    output logic bus_collision_flag,
    // open-drain lines: output is always low, enable pulls the line
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe
);

    iccd_regs_t r_q;
    iccd_regs_t r_d;

    logic sda_hi;
    logic scl_hi;
    logic cnt_zero;
    logic collide;

    assign sda_hi = r_q.sda_s;
    assign scl_hi = r_q.scl_s;
    assign cnt_zero = (r_q.cnt == ICCD_CNT_RST);

    always_comb
    begin
        r_d = r_q;
        collide = 1'b0;
        r_d.done = 1'b0;
        // first stage feeds the second only
        r_d.sda_m = sda_i;
        r_d.sda_s = r_q.sda_m;
        r_d.scl_m = scl_i;
        r_d.scl_s = r_q.scl_m;
        if (!cnt_zero)
        begin
            r_d.cnt = r_q.cnt - 7'h01;
        end
        case (r_q.st)
            ST_IDLE:
            begin
                if (start_req)
                begin
                    r_d.start_en = 1'b1;
                    r_d.sda_drv = 1'b0;
                    r_d.scl_drv = 1'b0;
                    r_d.st = ST_S_CHK;
                end
                else if (rstart_req)
                begin
                    // master holds SCL low from the last bit, lets SDA float
                    r_d.rstart_en = 1'b1;
                    r_d.sda_drv = 1'b0;
                    r_d.scl_drv = 1'b1;
                    r_d.st = ST_RS_WSDA;
                end
                else if (stop_req)
                begin
                    r_d.stop_en = 1'b1;
                    r_d.sda_drv = 1'b1;
                    r_d.scl_drv = 1'b1;
                    r_d.st = ST_P_WSDA;
                end
            end
            ST_S_CHK:
            begin
                if (!sda_hi || !scl_hi)
                begin
                    collide = 1'b1;
                end
                else
                begin
                    r_d.cnt = brg_reload_value;
                    r_d.st = ST_S_CNT1;
                end
            end
            ST_S_CNT1:
            begin
                if (!scl_hi && sda_hi)
                begin
                    collide = 1'b1;
                end
                else if (!sda_hi)
                begin
                    // another master started first; counter restarts
                    r_d.sda_drv = 1'b1;
                    r_d.cnt = brg_reload_value;
                    r_d.st = ST_S_CNT2;
                end
                else if (cnt_zero)
                begin
                    r_d.sda_drv = 1'b1;
                    r_d.cnt = brg_reload_value;
                    r_d.st = ST_S_CNT2;
                end
            end
            ST_S_CNT2:
            begin
                // SCL is not watched here: a low SCL is no collision
                if (cnt_zero)
                begin
                    r_d.scl_drv = 1'b1;
                    r_d.start_en = 1'b0;
                    r_d.done = 1'b1;
                    r_d.st = ST_IDLE;
                end
            end
            ST_RS_WSDA:
            begin
                if (sda_hi)
                begin
                    r_d.cnt = brg_reload_value;
                    r_d.st = ST_RS_CNT1;
                end
            end
            ST_RS_CNT1:
            begin
                if (cnt_zero)
                begin
                    r_d.scl_drv = 1'b0;
                    r_d.st = ST_RS_WSCL;
                end
            end
            ST_RS_WSCL:
            begin
                if (scl_hi)
                begin
                    if (!sda_hi)
                    begin
                        collide = 1'b1;
                    end
                    else
                    begin
                        r_d.cnt = brg_reload_value;
                        r_d.st = ST_RS_CNT2;
                    end
                end
            end
            ST_RS_CNT2:
            begin
                // a falling SDA is tolerated; only SCL is policed
                if (!scl_hi)
                begin
                    collide = 1'b1;
                end
                else if (cnt_zero)
                begin
                    r_d.sda_drv = 1'b1;
                    r_d.cnt = brg_reload_value;
                    r_d.st = ST_RS_CNT3;
                end
            end
            ST_RS_CNT3:
            begin
                if (cnt_zero)
                begin
                    r_d.scl_drv = 1'b1;
                    r_d.rstart_en = 1'b0;
                    r_d.done = 1'b1;
                    r_d.st = ST_IDLE;
                end
            end
            ST_P_WSDA:
            begin
                if (!sda_hi)
                begin
                    r_d.scl_drv = 1'b0;
                    r_d.st = ST_P_WSCL;
                end
            end
            ST_P_WSCL:
            begin
                // waiting here also stretches for a slow slave
                if (scl_hi)
                begin
                    r_d.cnt = brg_reload_value;
                    r_d.st = ST_P_CNT1;
                end
            end
            ST_P_CNT1:
            begin
                if (!scl_hi)
                begin
                    collide = 1'b1;
                end
                else if (cnt_zero)
                begin
                    r_d.sda_drv = 1'b0;
                    r_d.cnt = brg_reload_value;
                    r_d.st = ST_P_CNT2;
                end
            end
            ST_P_CNT2:
            begin
                if (cnt_zero)
                begin
                    if (!sda_hi)
                    begin
                        collide = 1'b1;
                    end
                    else
                    begin
                        r_d.stop_en = 1'b0;
                        r_d.done = 1'b1;
                        r_d.st = ST_IDLE;
                    end
                end
            end
            default:
            begin
                r_d.st = ST_IDLE;
            end
        endcase
        if (collide)
        begin
            r_d.sda_drv = 1'b0;
            r_d.scl_drv = 1'b0;
            r_d.start_en = 1'b0;
            r_d.rstart_en = 1'b0;
            r_d.stop_en = 1'b0;
            r_d.cnt = ICCD_CNT_RST;
            r_d.st = ST_IDLE;
        end
        // a collision in the clearing cycle keeps the flag set
        if (flag_clear)
        begin
            r_d.flag = 1'b0;
        end
        if (collide)
        begin
            r_d.flag = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            r_q.st <= ST_IDLE;
            r_q.cnt <= ICCD_CNT_RST;
            r_q.sda_drv <= 1'b0;
            r_q.scl_drv <= 1'b0;
            r_q.flag <= ICCD_FLAG_RST;
            r_q.start_en <= 1'b0;
            r_q.rstart_en <= 1'b0;
            r_q.stop_en <= 1'b0;
            r_q.done <= 1'b0;
            r_q.sda_m <= ICCD_LINE_RST;
            r_q.sda_s <= ICCD_LINE_RST;
            r_q.scl_m <= ICCD_LINE_RST;
            r_q.scl_s <= ICCD_LINE_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign start_en = r_q.start_en;
    assign rstart_en = r_q.rstart_en;
    assign stop_en = r_q.stop_en;
    assign cond_done = r_q.done;
    assign bus_collision_flag = r_q.flag;
    assign sda_o = 1'b0;
    assign sda_oe = r_q.sda_drv;
    assign scl_o = 1'b0;
    assign scl_oe = r_q.scl_drv;

endmodule
`default_nettype wire

/* bench/iccd_core_properties.sv */
// concurrent checks on the condition generator ports
`timescale 1ns/100ps
`default_nettype none
module iccd_core_properties
    import iccd_pkg::*;
(
    // clock, reset and requests
    input wire logic mclk, srst, start_req, rstart_req, stop_req, flag_clear,
    // status and lines
    input wire logic start_en, rstart_en, stop_en, cond_done, bus_collision_flag,
    input wire logic sda_oe, scl_oe, scl_i, sda_i
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire idle = !start_en && !rstart_en && !stop_en;
    property p_abort;
        $rose(bus_collision_flag) |-> idle && !sda_oe && !scl_oe;
    endproperty
    a_abort: assert property (p_abort)
        else $error("collision left lines or enables held");
    property p_sticky;
        bus_collision_flag && !flag_clear |=> bus_collision_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("collision flag dropped");
    property p_start_go;
        idle && start_req && !sda_oe && !scl_oe |=> start_en && !sda_oe && !scl_oe;
    endproperty
    a_start_go: assert property (p_start_go)
        else $error("start not begun with lines released");
    property p_rs_go;
        idle && !start_req && rstart_req |=> rstart_en && scl_oe && !sda_oe;
    endproperty
    a_rs_go: assert property (p_rs_go)
        else $error("repeated start not begun with sda released");
    property p_stop_go;
        idle && !start_req && !rstart_req && stop_req |=> stop_en && sda_oe && scl_oe;
    endproperty
    a_stop_go: assert property (p_stop_go)
        else $error("stop not begun with sda driven");
    // scl held low across the request must abort within a few cycles
    property p_scl_low;
        (!scl_i)[*3] ##0 (idle && start_req) ##1 (!scl_i)[*2]
            |-> ##[0:3] (bus_collision_flag && idle);
    endproperty
    a_scl_low: assert property (p_scl_low)
        else $error("start with scl low not aborted");
    property p_sda_held;
        start_en && sda_oe |=> !$rose(bus_collision_flag);
    endproperty
    a_sda_held: assert property (p_sda_held)
        else $error("collision after start drove sda");
    // sda seen low in the first count must start the fall at once
    property p_sda_early;
        (!sda_i)[*3] ##0 (start_en && !sda_oe) |=> sda_oe || !start_en;
    endproperty
    a_sda_early: assert property (p_sda_early)
        else $error("start did not drive sda early");
    property p_start_end;
        $fell(start_en) && !bus_collision_flag && !$past(srst) |-> cond_done && sda_oe && scl_oe;
    endproperty
    a_start_end: assert property (p_start_end)
        else $error("start ended without done and scl low");
    c_done: cover property (cond_done);
    c_coll: cover property ($rose(bus_collision_flag));
    c_stop: cover property ($fell(stop_en) && cond_done);
endmodule
`default_nettype wire

/* bench/iccd_peer.sv */
// other bus parties: wired-and lines with pull-ups and scripted pulls
`timescale 1ns/100ps
`default_nettype none
module iccd_peer (
    // clock and script
    input wire logic mclk,
    input wire logic [2:0] mode,
    // device enables and line levels
    input wire logic sda_oe,
    input wire logic scl_oe,
    output logic sda_i,
    output logic scl_i
);
    logic [2:0] ph_q = 3'h0;
    logic [3:0] rel_q = 4'h0;
    // 1 hold sda, 2 hold scl, 3 sda low while scl high, 4 clock scl, 5 stretch scl
    // mode 4 clocks scl at 320 ns, waiting at phase 0 until scl reads high, then running all 8 phases even while held
    wire pull_sda = mode == 3'h1 || (mode == 3'h3 && scl_i);
    wire pull_scl = mode == 3'h2 || (mode == 3'h4 && ph_q[2]) || (mode == 3'h5 && rel_q < 4'h8);
    assign sda_i = !(sda_oe || pull_sda);
    assign scl_i = !(scl_oe || pull_scl);
    always_ff @(posedge mclk)
    begin
        ph_q <= (mode == 3'h4 && (scl_i || ph_q != 3'h0)) ? ph_q + 3'h1 : 3'h0;
        rel_q <= scl_oe ? 4'h0 : rel_q + 4'(rel_q != 4'hF);
    end
endmodule
`default_nettype wire

/* bench/iccd_core_test.sv */
// self-checking bench for the condition generator
`timescale 1ns/100ps
`default_nettype none
module iccd_core_test;
    import iccd_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic start_req = 1'b0, rstart_req = 1'b0, stop_req = 1'b0, flag_clear = 1'b0;
    logic [ICCD_BRG_W-1:0] brg_reload_value = 7'h04;
    logic [2:0] mode = 3'h0;
    logic start_en, rstart_en, stop_en, cond_done, bus_collision_flag;
    logic sda_o, scl_o, sda_oe, scl_oe, sda_i, scl_i;
    logic flag_q = 1'b0;
    logic [1:0] exp_q[$];
    int fail_count = 0;
    int total_checks = 0;
    iccd_core uut (.mclk, .srst, .start_req, .rstart_req, .stop_req, .brg_reload_value,
        .flag_clear, .start_en, .rstart_en, .stop_en, .cond_done, .bus_collision_flag,
        .sda_i, .sda_o, .sda_oe, .scl_i, .scl_o, .scl_oe);
    iccd_peer peer (.mclk, .mode, .sda_oe, .scl_oe, .sda_i, .scl_i);
    initial forever #20 mclk = ~mclk;
    task automatic check(input string name, input logic [1:0] seen, input logic [1:0] want);
        total_checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // outcomes are taken on the falling edge, where registered outputs have settled
    always @(negedge mclk)
    begin
        flag_q <= bus_collision_flag;
        if (!srst && (cond_done === 1'b1 || (bus_collision_flag === 1'b1 && flag_q === 1'b0)))
            check("outcome", {cond_done, bus_collision_flag}, exp_q.pop_front());
    end
    // kind 0 start, 1 repeated start, 2 stop; late delays the peer script
    task automatic run(input int kind, input logic [2:0] md, input int late, input logic [1:0] want);
        int i;
        mode = (late == 0) ? md : 3'h0;
        brg_reload_value = 7'(4 + $urandom_range(3));
        // gap lets the synchronisers see the new line levels first
        repeat (4) @(posedge mclk);
        #2;
        exp_q.push_back(want);
        start_req = kind == 0;
        rstart_req = kind == 1;
        stop_req = kind == 2;
        @(posedge mclk);
        #2;
        {start_req, rstart_req, stop_req} = 3'h0;
        for (i = 0; i < 3000; i++)
        begin
            @(posedge mclk);
            #2;
            if (i == late)
                mode = md;
            if (!(start_en || rstart_en || stop_en))
                break;
        end
        @(negedge mclk);
        #1;
        check("pending", 2'(exp_q.size()), 2'h0);
        if (i == 3000)
        begin
            fail_count++;
            close_out();
        end
        if (kind == 2)
        begin
            check("stop lines", {sda_oe, scl_oe}, 2'h0);
            check("drive level", {sda_o, scl_o}, 2'h0);
        end
        if (want[0])
        begin
            check("lines released", {sda_oe, scl_oe}, 2'h0);
            repeat (3) @(posedge mclk);
            #2;
            check("flag held", {1'b0, bus_collision_flag}, 2'h1);
            flag_clear = 1'b1;
            @(posedge mclk);
            #2;
            flag_clear = 1'b0;
            check("flag cleared", {1'b0, bus_collision_flag}, 2'h0);
        end
        @(posedge mclk);
        #2;
    endtask
    initial
    begin
        void'($urandom(32'hBBD466CE));
        repeat (8) @(posedge mclk);
        #2;
        srst = 1'b0;
        check("flag after reset", {1'b0, bus_collision_flag}, 2'h0);
        run(0, 3'h0, 0, 2'h2);
        run(2, 3'h5, 0, 2'h2);
        run(0, 3'h2, 0, 2'h1);
        run(0, 3'h1, 0, 2'h1);
        run(0, 3'h2, 2, 2'h1);
        run(0, 3'h1, 2, 2'h2);
        run(2, 3'h0, 0, 2'h2);
        run(0, 3'h0, 0, 2'h2);
        run(1, 3'h0, 0, 2'h2);
        run(1, 3'h3, 0, 2'h1);
        run(0, 3'h0, 0, 2'h2);
        run(1, 3'h4, 0, 2'h1);
        run(0, 3'h0, 0, 2'h2);
        run(2, 3'h1, 0, 2'h1);
        run(0, 3'h0, 0, 2'h2);
        run(2, 3'h4, 0, 2'h1);
        close_out();
    end
endmodule
bind iccd_core iccd_core_properties chk (.mclk, .srst, .start_req, .rstart_req, .stop_req,
    .flag_clear, .start_en, .rstart_en, .stop_en, .cond_done, .bus_collision_flag,
    .sda_oe, .scl_oe, .scl_i, .sda_i);
`default_nettype wire
